// file: adc_control_status_sequencer.sv
// Control/status register, mode register and conversion sequencer
// for one successive-approximation converter, with an APB slave.
// Assumes the converter core answers each start with one done pulse
// on pclk, and that dma_ack marks bus cycles of the interrupt's DMA.
// How it works
// - Single mode sets the end flag when the chosen channel finishes.
// - Scan mode sets the end flag only after the whole group finishes.
// - Flag clears by writing 0 after reading it as 1; writing 1 ignored.
// - A DMA read of any result register clears the end flag.
// - Interrupt request is flag AND enable, off when enable is 0.
// - Writing run 0 stops conversion at once and returns to idle.
// - Writing run 1 starts conversion per current mode and channel.
// - Single mode clears the run bit itself when conversion ends.
// - Scan mode repeats the group until run is written 0 or reset.
// - Reserved bit 4 reads zero and ignores writes.
// - Single mode converts the input equal to the code; 1XXX banned.
// - Four-scan starts at input 0 or 4, low bits plus one give count.
// - Eight-scan code n converts inputs 0 through n; 1XXX banned.
// - Each result lands left-aligned in its channel register, low zero.
// - Mode upper bit 0 single, 10 four-scan, 11 eight-scan.
// - After the last group channel the scan restarts at the first.
//
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/10ps
module adc_control_status_sequencer import adc_pkg::*; (
  input wire logic pclk, // Bus clock, 100 MHz
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction, 1 write
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  input wire logic dma_ack, // Access made by the DMA controller
  output logic conv_start, // One-cycle start to the core
  output logic conv_abort, // One-cycle abort to the core
  output logic [CH_W-1:0] conv_channel, // Channel being converted
  input wire logic conv_done, // One-cycle done from the core
  input wire logic [RESULT_W-1:0] conv_result, // Result with done
  output logic conv_end_irq // Conversion-end interrupt request
);

  function automatic decode_t decode(input logic [7:0] a);
    if (a == CSR_ADDR) begin
      decode = DEC_CSR;
    end else if (a == CFG_ADDR) begin
      decode = DEC_CFG;
    end else if (a[7:5] == RES_PAGE && a[1:0] == 2'h0) begin
      decode = DEC_RES;
    end else begin
      decode = DEC_NONE;
    end
  endfunction

  // First channel of the group for a mode and channel code
  function automatic logic [CH_W-1:0] first_ch(input logic [1:0] m,
                                               input logic [2:0] s);
    if (!m[1]) begin
      first_ch = s;
    end else if (m == MODE_SCAN4) begin
      first_ch = {s[2], 2'h0};
    end else begin
      first_ch = 3'h0;
    end
  endfunction

  // Last channel of the group
  function automatic logic [CH_W-1:0] last_ch(input logic [1:0] m,
                                              input logic [2:0] s);
    if (!m[1]) begin
      last_ch = s;
    end else if (m == MODE_SCAN4) begin
      last_ch = {s[2], s[1:0]};
    end else begin
      last_ch = s;
    end
  endfunction

  logic flag, next_flag;
  logic ie, next_ie;
  logic run, next_run;
  logic [3:0] sel, next_sel;
  logic [1:0] mode, next_mode;
  logic armed, next_armed;
  seq_state_t state, next_state;
  logic [CH_W-1:0] next_ch;
  logic next_conv_start, next_conv_abort, next_irq;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  logic [15:0] res_word;
  decode_t dec;
  logic xfer, wr, rd, csr_wr, csr_stop, csr_go, done_ev;
  logic set_ev, clr_ev;

  assign dec = decode(paddr);
  assign xfer = psel && penable && pready;
  assign wr = xfer && pwrite;
  assign rd = xfer && !pwrite;
  assign csr_wr = wr && dec == DEC_CSR;
  assign csr_stop = csr_wr && !pwdata[RUN_BIT];
  assign csr_go = csr_wr && pwdata[RUN_BIT];
  assign done_ev = state == SEQ_CONVERT && conv_done;

  adc_result_regs u_results (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(done_ev && !csr_stop),
    .wr_idx(conv_channel),
    .wr_data(conv_result),
    .rd_idx(paddr[4:2]),
    .rd_data(res_word)
  );

  // Bus side: zero wait states, data prepared in the setup cycle
  always_comb begin
    next_pready = psel && !penable;
    next_pslverr = 1'b0;
    next_prdata = prdata;
    if (psel && !penable) begin
      next_pslverr = dec == DEC_NONE;
      if (!pwrite) begin
        if (dec == DEC_CSR) begin
          // Reserved bit forced low
          next_prdata = {24'h0, flag, ie, run, 1'b0, sel};
        end else if (dec == DEC_CFG) begin
          next_prdata = {26'h0, mode, 4'h0};
        end else if (dec == DEC_RES) begin
          next_prdata = {16'h0, res_word};
        end else begin
          next_prdata = 32'h0;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= next_pready;
      pslverr <= next_pslverr;
      prdata <= next_prdata;
    end
  end

  // Registers and sequencer
  always_comb begin
    next_ie = ie;
    next_run = run;
    next_sel = sel;
    next_mode = mode;
    next_armed = armed;
    next_state = state;
    next_ch = conv_channel;
    next_conv_start = 1'b0;
    next_conv_abort = 1'b0;
    set_ev = 1'b0;
    clr_ev = 1'b0;
    if (csr_wr) begin
      next_ie = pwdata[IE_BIT];
      next_sel = pwdata[SEL_MSB:0];
      next_run = pwdata[RUN_BIT];
      // Only a write of 0 after a read of 1 clears; 1 does nothing
      clr_ev = !pwdata[FLAG_BIT] && armed;
      next_armed = 1'b0;
    end
    if (rd && dec == DEC_CSR && prdata[FLAG_BIT]) begin
      next_armed = 1'b1;
    end
    if (rd && dec == DEC_RES && dma_ack) begin
      clr_ev = 1'b1;
    end
    if (wr && dec == DEC_CFG) begin
      next_mode = {pwdata[SCAN_EN_BIT], pwdata[SCAN_WIDTH_BIT]};
    end
    case (state)
      SEQ_IDLE: begin
        if (csr_go) begin
          // Channel code comes from the same write that sets run
          next_ch = first_ch(mode, pwdata[2:0]);
          next_conv_start = 1'b1;
          next_state = SEQ_CONVERT;
        end
      end
      SEQ_CONVERT: begin
        if (csr_stop) begin
          next_conv_abort = 1'b1;
          next_state = SEQ_IDLE;
        end else if (conv_done) begin
          if (!mode[1]) begin
            set_ev = 1'b1;
            next_run = 1'b0;
            next_state = SEQ_IDLE;
          end else if (conv_channel == last_ch(mode, sel[2:0])) begin
            set_ev = 1'b1;
            next_ch = first_ch(mode, sel[2:0]);
            next_conv_start = 1'b1;
          end else begin
            next_ch = conv_channel + 3'h1;
            next_conv_start = 1'b1;
          end
        end
      end
      default: begin
        next_state = SEQ_IDLE;
      end
    endcase
    // A new end event outranks a clear in the same cycle
    next_flag = set_ev ? 1'b1 : (clr_ev ? 1'b0 : flag);
    next_irq = next_flag && next_ie;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag <= CSR_RESET[FLAG_BIT];
      ie <= CSR_RESET[IE_BIT];
      run <= CSR_RESET[RUN_BIT];
      sel <= CSR_RESET[SEL_MSB:0];
      mode <= MODE_RESET;
      armed <= 1'b0;
      state <= SEQ_IDLE;
      conv_channel <= 3'h0;
      conv_start <= 1'b0;
      conv_abort <= 1'b0;
      conv_end_irq <= 1'b0;
    end else begin
      flag <= next_flag;
      ie <= next_ie;
      run <= next_run;
      sel <= next_sel;
      mode <= next_mode;
      armed <= next_armed;
      state <= next_state;
      conv_channel <= next_ch;
      conv_start <= next_conv_start;
      conv_abort <= next_conv_abort;
      conv_end_irq <= next_irq;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_stop_write;
    csr_wr && !pwdata[RUN_BIT];
  endsequence

  sequence s_finish;
    done_ev && !csr_stop;
  endsequence

  sequence s_restart;
    conv_start && run && state == SEQ_CONVERT;
  endsequence

  property p_flag_rise;
    $rose(flag) |->
      $past(done_ev && (!mode[1] || conv_channel == last_ch(mode, sel[2:0])));
  endproperty
  a_flag_rise: assert property (p_flag_rise)
    else $error("end flag rose without a finished conversion or group");

  property p_single_flag;
    s_finish ##0 !mode[1] |=> flag && !run && state == SEQ_IDLE;
  endproperty
  a_single_flag: assert property (p_single_flag)
    else $error("single conversion end did not set flag and clear run");

  property p_write_one_keeps;
    csr_wr && pwdata[FLAG_BIT] && flag |=> flag;
  endproperty
  a_write_one_keeps: assert property (p_write_one_keeps)
    else $error("writing 1 to the end flag changed it");

  property p_clear_after_read;
    csr_wr && !pwdata[FLAG_BIT] && armed && !set_ev |=> !flag;
  endproperty
  a_clear_after_read: assert property (p_clear_after_read)
    else $error("write 0 after read of 1 did not clear the flag");

  property p_dma_clear;
    rd && dec == DEC_RES && dma_ack && !set_ev |=> !flag;
  endproperty
  a_dma_clear: assert property (p_dma_clear)
    else $error("DMA result read did not clear the flag");

  property p_irq;
    ##1 conv_end_irq == (flag && ie);
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt request differs from flag and enable");

  property p_stop;
    s_stop_write ##0 state == SEQ_CONVERT |=>
      conv_abort && state == SEQ_IDLE && !run ##1 !conv_start;
  endproperty
  a_stop: assert property (p_stop)
    else $error("run write of 0 did not stop conversion");

  property p_start;
    csr_go && state == SEQ_IDLE |=>
      s_restart ##0 conv_channel == first_ch(mode, sel[2:0]);
  endproperty
  a_start: assert property (p_start)
    else $error("run write of 1 did not start at the first channel");

  property p_scan_wrap;
    s_finish ##0 mode[1] && conv_channel == last_ch(mode, sel[2:0]) |=>
      s_restart ##0 flag && conv_channel == first_ch(mode, sel[2:0]);
  endproperty
  a_scan_wrap: assert property (p_scan_wrap)
    else $error("scan group did not restart at its first channel");

  property p_channel_range;
    conv_start |-> conv_channel >= first_ch(mode, sel[2:0]) &&
      conv_channel <= last_ch(mode, sel[2:0]);
  endproperty
  a_channel_range: assert property (p_channel_range)
    else $error("converted channel outside the selected group");

  property p_hold_wait;
    state == SEQ_CONVERT && !conv_done && !csr_stop |=>
      state == SEQ_CONVERT && conv_channel == $past(conv_channel) &&
      !conv_start;
  endproperty
  a_hold_wait: assert property (p_hold_wait)
    else $error("sequencer moved on without a done strobe");

  property p_reserved;
    pready && psel && !pwrite && dec == DEC_CSR |-> !prdata[RSVD_BIT];
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved bit read as one");

endmodule // adc_control_status_sequencer

// file: adc_pkg.sv
// Constants and types shared by the converter control block.
// Assumes a 100 MHz pclk and an 8-bit APB byte address.
package adc_pkg;

  // APB byte addresses, one aligned word per register
  localparam logic [7:0] CSR_ADDR = 8'h00;
  localparam logic [7:0] CFG_ADDR = 8'h04;
  localparam logic [7:0] RES_BASE_ADDR = 8'h20;
  localparam logic [2:0] RES_PAGE = 3'h1;

  // Control/status register fields
  localparam int FLAG_BIT = 7;
  localparam int IE_BIT = 6;
  localparam int RUN_BIT = 5;
  localparam int RSVD_BIT = 4;
  localparam int SEL_MSB = 3;

  // Configuration register fields
  localparam int SCAN_EN_BIT = 5;
  localparam int SCAN_WIDTH_BIT = 4;

  // Values after reset
  localparam logic [7:0] CSR_RESET = 8'h00;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [9:0] RESULT_RESET = 10'h000;

  // Mode field encodings
  localparam logic [1:0] MODE_SCAN4 = 2'h2;
  localparam logic [1:0] MODE_SCAN8 = 2'h3;

  // Converter geometry
  localparam int RESULT_W = 10;
  localparam int NUM_CH = 8;
  localparam int CH_W = 3;
  localparam int RES_PAD = 6;

  typedef enum logic [1:0] {
    DEC_CSR = 2'b00,
    DEC_CFG = 2'b01,
    DEC_RES = 2'b10,
    DEC_NONE = 2'b11
  } decode_t;

  typedef enum logic {
    SEQ_IDLE = 1'b0,
    SEQ_CONVERT = 1'b1
  } seq_state_t;

endpackage

// file: adc_result_regs.sv
// Per-channel conversion result storage, read as left-aligned words.
// Assumes writes come only from the sequencer on pclk.
`timescale 1ns/10ps
module adc_result_regs import adc_pkg::*; (
  input wire logic pclk, // Bus clock
  input wire logic presetn, // Async reset, active low
  input wire logic wr_en, // Store a finished result
  input wire logic [CH_W-1:0] wr_idx, // Channel of the result
  input wire logic [RESULT_W-1:0] wr_data, // Converted value
  input wire logic [CH_W-1:0] rd_idx, // Channel to read
  output logic [15:0] rd_data // Result, bits 15 to 6
);

  logic [RESULT_W-1:0] result_q [NUM_CH];
  logic [RESULT_W-1:0] next_result [NUM_CH];

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      always_comb begin
        next_result[gi] = result_q[gi];
        if (wr_en && wr_idx == CH_W'(gi)) begin
          next_result[gi] = wr_data;
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          result_q[gi] <= RESULT_RESET;
        end else begin
          result_q[gi] <= next_result[gi];
        end
      end
    end
  endgenerate

  // Low six bits always read zero
  assign rd_data = {result_q[rd_idx], {RES_PAD{1'b0}}};

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_result_stored;
    wr_en |=> result_q[$past(wr_idx)] == $past(wr_data);
  endproperty
  a_result_stored: assert property (p_result_stored)
    else $error("result not stored in its channel slot");

endmodule // adc_result_regs

// file: adc_core_model.sv
// Behavioural model of the converter core behind the sequencer.
// Assumes one start pulse per conversion and pclk as its only clock.
`timescale 1ns/10ps
module adc_core_model import adc_pkg::*; (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic conv_start, // Start pulse
  input wire logic conv_abort, // Abort pulse
  input wire logic [CH_W-1:0] conv_channel, // Channel to convert
  input wire logic [4:0] delay, // One less than the cycles from start taken to done
  output logic conv_done, // Done pulse
  output logic [RESULT_W-1:0] conv_result // Valid with done only
);
  logic busy;
  logic [4:0] cnt;
  logic [CH_W-1:0] ch;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= 1'b0;
      cnt <= 5'h00;
      ch <= 3'h0;
      conv_done <= 1'b0;
      conv_result <= 10'h000;
    end else begin
      conv_done <= 1'b0;
      // Garbage outside done so a late sample cannot look valid
      conv_result <= ~conv_result;
      if (conv_abort) begin
        busy <= 1'b0;
      end else if (conv_start) begin
        busy <= 1'b1;
        cnt <= delay;
        ch <= conv_channel;
      end else if (busy && cnt == 5'h00) begin
        busy <= 1'b0;
        conv_done <= 1'b1;
        conv_result <= {ch, 7'h35};
      end else if (busy) begin
        cnt <= cnt - 5'h01;
      end
    end
  end
endmodule // adc_core_model

// file: adc_control_status_sequencer_tb.sv
// Self-checking bench for the converter control and status block.
// Drives APB as bus master; the core model answers conversions.
`timescale 1ns/10ps
module adc_control_status_sequencer_tb;
  import adc_pkg::*;
  typedef struct packed {
    logic [7:0] cfg;
    logic [3:0] sel;
    logic [2:0] first;
    logic [2:0] last;
    logic [4:0] dly;
  } row_t;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic dma_ack = 0, pready, pslverr, errv;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdv;
  logic conv_start, conv_abort, conv_done, conv_end_irq;
  logic [CH_W-1:0] conv_channel;
  logic [RESULT_W-1:0] conv_result;
  logic [4:0] core_delay = 5'h02;
  logic [CH_W-1:0] starts[$];
  int n_fail = 0, samples_checked = 0, n_abort = 0, cycles = 0;
  row_t rows[9];
  row_t row;

  adc_control_status_sequencer uut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dma_ack(dma_ack), .conv_start(conv_start),
    .conv_abort(conv_abort), .conv_channel(conv_channel),
    .conv_done(conv_done), .conv_result(conv_result),
    .conv_end_irq(conv_end_irq));
  adc_core_model core (.pclk(pclk), .presetn(presetn),
    .conv_start(conv_start), .conv_abort(conv_abort),
    .conv_channel(conv_channel), .delay(core_delay),
    .conv_done(conv_done), .conv_result(conv_result));

  initial begin
    forever #5 pclk = ~pclk;
  end
  always @(negedge pclk) begin
    if (conv_start === 1'b1) starts.push_back(conv_channel);
    if (conv_abort === 1'b1) n_abort++;
  end
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      complete_run();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic dma);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    dma_ack <= dma;
    @(posedge pclk);
    penable <= 1'b1;
    // Data taken at the edge where pready is sampled high
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    dma_ack <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0);
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, 1'b0);
    chk(rdv, e);
  endtask
  task wait_irq;
    int k;
    k = 0;
    while (conv_end_irq !== 1'b1 && k < 400) begin
      @(negedge pclk);
      k++;
    end
  endtask
  function logic [31:0] csr_v(input logic f, input logic run,
    input logic [3:0] s);
    return {24'h0, f, 1'b1, run, 1'b0, s};
  endfunction
  function logic [31:0] res_v(input logic [CH_W-1:0] c);
    return {16'h0, c, 7'h35, 6'h00};
  endfunction
  task complete_run;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    int n, k;
    rows = '{{8'h00, 4'h0, 3'h0, 3'h0, 5'h00},
      {8'h00, 4'h7, 3'h7, 3'h7, 5'h05}, {8'h10, 4'h3, 3'h3, 3'h3, 5'h01},
      {8'h20, 4'h3, 3'h0, 3'h3, 5'h0C}, {8'h20, 4'h4, 3'h4, 3'h4, 5'h0C},
      {8'h20, 4'h6, 3'h4, 3'h6, 5'h0C}, {8'h30, 4'h0, 3'h0, 3'h0, 5'h0C},
      {8'h30, 4'h2, 3'h0, 3'h2, 5'h0C}, {8'h30, 4'h7, 3'h0, 3'h7, 5'h0C}};
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(CSR_ADDR, 32'h0);
    rd_chk(CFG_ADDR, 32'h0);
    wr(CSR_ADDR, 32'h50);
    rd_chk(CSR_ADDR, 32'h40);
    wr(CSR_ADDR, 32'hC0);
    rd_chk(CSR_ADDR, 32'h40);
    for (int r = 0; r < 9; r++) begin
      row = rows[r];
      n = row.last - row.first + 1;
      core_delay <= row.dly;
      wr(CFG_ADDR, {24'h0, row.cfg});
      starts.delete();
      wr(CSR_ADDR, csr_v(1'b0, 1'b1, row.sel));
      wait_irq();
      chk(conv_end_irq, 32'h1);
      for (int i = 0; i < n; i++)
        chk(starts[i], 3'(row.first + i));
      rd_chk(CSR_ADDR, csr_v(1'b1, row.cfg[5], row.sel));
      wr(CSR_ADDR, csr_v(1'b0, row.cfg[5], row.sel));
      rd_chk(CSR_ADDR, csr_v(1'b0, row.cfg[5], row.sel));
      if (row.cfg[5]) begin
        wait_irq();
        for (int i = 0; i < n; i++)
          chk(starts[n + i], 3'(row.first + i));
        wr(CSR_ADDR, csr_v(1'b0, 1'b0, row.sel));
        rd_chk(CSR_ADDR, csr_v(1'b1, 1'b0, row.sel));
        wr(CSR_ADDR, csr_v(1'b0, 1'b0, row.sel));
      end else begin
        chk(starts.size(), 32'h1);
      end
      rd_chk(RES_BASE_ADDR + 8'(4 * row.last), res_v(row.last));
      rd_chk(CSR_ADDR, csr_v(1'b0, 1'b0, row.sel));
    end
    // Stop before the slow core can answer
    n = n_abort;
    core_delay <= 5'h14;
    wr(CFG_ADDR, 32'h0);
    wr(CSR_ADDR, 32'h22);
    wr(CSR_ADDR, 32'h02);
    rd_chk(CSR_ADDR, 32'h02);
    chk(n_abort, n + 1);
    core_delay <= 5'h02;
    wr(CSR_ADDR, 32'h25);
    k = 0;
    do begin
      apb(1'b0, CSR_ADDR, 32'h0, 1'b0);
      k++;
    end while (rdv[7] !== 1'b1 && k < 10);
    chk(rdv, 32'h85);
    chk(conv_end_irq, 32'h0);
    wr(CSR_ADDR, 32'hC5);
    rd_chk(CSR_ADDR, 32'hC5);
    chk(conv_end_irq, 32'h1);
    apb(1'b0, RES_BASE_ADDR + 8'h14, 32'h0, 1'b0);
    chk(conv_end_irq, 32'h1);
    apb(1'b0, RES_BASE_ADDR + 8'h14, 32'h0, 1'b1);
    chk(rdv, res_v(3'h5));
    rd_chk(CSR_ADDR, 32'h45);
    chk(conv_end_irq, 32'h0);
    apb(1'b0, 8'h08, 32'h0, 1'b0);
    chk(errv, 32'h1);
    chk(rdv, 32'h0);
    // Reset in mid-scan must stop it and zero everything
    wr(CFG_ADDR, 32'h30);
    wr(CSR_ADDR, 32'h67);
    repeat (20) @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({conv_start, conv_abort, conv_end_irq, conv_channel}, 32'h0);
    presetn <= 1'b1;
    starts.delete();
    rd_chk(CSR_ADDR, 32'h0);
    rd_chk(CFG_ADDR, 32'h0);
    repeat (20) @(posedge pclk);
    chk(starts.size(), 32'h0);
    complete_run();
  end
endmodule // adc_control_status_sequencer_tb
